// *** phy_ctrl_pkg.sv ***
// Shared constants and types for the 10BASE-T physical layer control block
package phy_ctrl_pkg;

    // Clock and timing figures
    localparam int unsigned CLOCK_PERIOD_NS = 20;
    localparam int unsigned NS_PER_MS       = 1000000;
    localparam int unsigned ATTEMPT_TIME_MS = 250;
    localparam int unsigned BREAK_TIME_MS   = 1500;
    localparam int unsigned FLP_GAP_TIME_MS = 16;
    localparam int unsigned MAX_FRAME_BITS  = 12144;
    localparam int unsigned BIT_TIME_NS     = 100;

    // Derived cycle counts; every figure divides evenly at 50 MHz
    localparam int unsigned ATTEMPT_CYCLES = ATTEMPT_TIME_MS * (NS_PER_MS / CLOCK_PERIOD_NS);
    localparam int unsigned BREAK_CYCLES   = BREAK_TIME_MS * (NS_PER_MS / CLOCK_PERIOD_NS);
    localparam int unsigned FLP_GAP_CYCLES = FLP_GAP_TIME_MS * (NS_PER_MS / CLOCK_PERIOD_NS);
    localparam int unsigned JABBER_CYCLES  = (MAX_FRAME_BITS * BIT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // Link code word layout
    localparam int unsigned LCW_WIDTH    = 16;
    localparam int unsigned LCW_SEL_LSB  = 0;
    localparam int unsigned LCW_SEL_W    = 5;
    localparam logic [4:0]  LCW_SELECTOR = 5'h01;
    localparam int unsigned LCW_10HD     = 5;
    localparam int unsigned LCW_10FD     = 6;
    localparam int unsigned LCW_PAUSE    = 10;
    localparam int unsigned LCW_RFAULT   = 13;
    localparam int unsigned LCW_ACK      = 14;

    // Negotiation failure status layout
    localparam int unsigned FAIL_W       = 8;
    localparam int unsigned FAIL_INCOMPAT = 7;
    localparam int unsigned FAIL_TIMEOUT  = 5;
    localparam logic [7:0]  FAIL_RESET    = 8'h00;

    typedef enum logic [2:0] {
        PHASE_OFF     = 3'b000,
        PHASE_ATTEMPT = 3'b001,
        PHASE_BREAK   = 3'b010,
        PHASE_LINKED  = 3'b011,
        PHASE_MANUAL  = 3'b100
    } phase_type;

endpackage

// *** phy_interval_timer.sv ***
// Restartable interval counter that pulses at the end of every interval
`timescale 1ns/1ps
`default_nettype none
module phy_interval_timer #(
    parameter int unsigned WIDTH = 27,
    parameter int unsigned LIMIT = 1000
) (
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_clear,
    input  wire logic i_run,
    output logic      o_done
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
    } timer_state_type;

    localparam logic [WIDTH-1:0] LAST = WIDTH'(LIMIT - 1);

    timer_state_type state;
    timer_state_type next_state;

    assign o_done = i_run && !i_clear && (state.count == LAST);

    always_comb begin
        next_state = state;
        if (i_clear) begin
            next_state.count = '0;
        end else if (i_run) begin
            if (state.count == LAST) begin
                next_state.count = '0;
            end else begin
                next_state.count = state.count + WIDTH'(1);
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule
`default_nettype wire

// *** phy_jabber_guard.sv ***
// Transmit length watchdog that blocks an overlong frame until it ends
`timescale 1ns/1ps
`default_nettype none
module phy_jabber_guard #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned LIMIT = 60720
) (
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_enable,
    input  wire logic i_tx_active,
    output logic      o_trip,
    output logic      o_blocking
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             blocking;
    } guard_state_type;

    localparam logic [WIDTH-1:0] LAST = WIDTH'(LIMIT - 1);

    guard_state_type state;
    guard_state_type next_state;

    assign o_trip     = i_enable && i_tx_active && !state.blocking && (state.count == LAST);
    assign o_blocking = state.blocking;

    always_comb begin
        next_state = state;
        if (!i_tx_active) begin
            // Block is held to the end of the frame so no tail fragment escapes
            next_state.count    = '0;
            next_state.blocking = 1'b0;
        end else begin
            if (state.count != LAST) begin
                next_state.count = state.count + WIDTH'(1);
            end
            if (o_trip) begin
                next_state.blocking = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule
`default_nettype wire

// *** tenbase_t_phy_control.sv ***
// Control and monitoring logic of the 10BASE-T physical layer
// Behaviour
// - Capabilities go out as 16-bit link code words in fast link pulse bursts.
// - Failed negotiation pulses failure, records cause, falls back to half duplex.
// - Successful negotiation pulses complete and never failure in the same event.
// - Always advertise 10 Mb/s; pick full duplex when the partner offers it.
// - Advertise pause capability while the pause-advertise input is high.
// - Disabling then re-enabling transmitter or receiver restarts negotiation.
// - A legacy partner without negotiation gives half-duplex operation.
// - Attempt for 250 ms, then break link 1.5 s, and repeat.
// - During break link ignore partner words and do not negotiate.
// - Loopback routes transmit to receive and isolates from the line.
// - With link check on, link loss stops transmit and, outside loopback, receive; report link.
// - With link check off, operate regardless of link pulses.
// - Smart squelch qualifies receive by amplitude and timing.
// - Auto polarity corrects reversed receive and reports it.
// - Without auto polarity, manual invert reverses receive data.
// - Jabber protection blocks overlong transmit and pulses jabber detected.
// - A jabber event clears loopback mode.
// - Duplex select is writable only while enable_a is disabled.
`timescale 1ns/1ps
`default_nettype none
module tenbase_t_phy_control #(
    parameter int unsigned ATTEMPT_CYCLES = phy_ctrl_pkg::ATTEMPT_CYCLES,
    parameter int unsigned BREAK_CYCLES   = phy_ctrl_pkg::BREAK_CYCLES,
    parameter int unsigned FLP_GAP_CYCLES = phy_ctrl_pkg::FLP_GAP_CYCLES,
    parameter int unsigned JABBER_CYCLES  = phy_ctrl_pkg::JABBER_CYCLES
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_phy_power_enable,
    input  wire logic        i_tx_path_enable,
    input  wire logic        i_rx_path_enable,
    input  wire logic        i_duplex_write,
    input  wire logic        i_duplex_value,
    input  wire logic        i_loopback_write,
    input  wire logic        i_loopback_value,
    input  wire logic        i_enable_a,
    input  wire logic        i_pause_advertise,
    input  wire logic        i_smart_squelch_enable,
    input  wire logic        i_link_check_enable,
    input  wire logic        i_jabber_enable,
    input  wire logic        i_auto_polarity_enable,
    input  wire logic        i_manual_polarity_invert,
    input  wire logic        i_wake_clear,
    input  wire logic        i_partner_word_valid,
    input  wire logic [15:0] i_partner_word,
    input  wire logic        i_partner_nlp,
    input  wire logic        i_link_pulse_ok,
    input  wire logic        i_line_rx_valid,
    input  wire logic        i_line_rx_data,
    input  wire logic        i_rx_amplitude_ok,
    input  wire logic        i_rx_timing_ok,
    input  wire logic        i_polarity_reversed_detect,
    input  wire logic        i_mac_tx_en,
    input  wire logic        i_mac_tx_data,
    output logic             o_duplex_select,
    output logic             o_loopback,
    output logic             o_remote_fault,
    output logic             o_link_good,
    output logic             o_polarity_flipped,
    output logic             o_wake_event_flag,
    output logic [7:0]       o_negotiation_fail_status_reg,
    output logic             o_neg_complete,
    output logic             o_neg_failed,
    output logic             o_jabber_detected,
    output logic [15:0]      o_local_word,
    output logic             o_flp_burst,
    output logic             o_line_tx_en,
    output logic             o_line_tx_data,
    output logic             o_mac_rx_valid,
    output logic             o_mac_rx_data
);
    typedef struct packed {
        phy_ctrl_pkg::phase_type phase;
        logic                    duplex;
        logic                    loopback;
        logic                    remote_fault;
        logic                    link_good;
        logic                    pol_flip;
        logic                    wake;
        logic                    ack;
        logic [7:0]              fail_status;
        logic                    complete_pulse;
        logic                    failed_pulse;
        logic                    jabber_pulse;
        logic                    burst_pulse;
        logic [15:0]             local_word;
        logic                    tx_en;
        logic                    tx_data;
        logic                    rx_valid;
        logic                    rx_data;
    } ctrl_state_type;

    localparam int unsigned ATTEMPT_W = $clog2(ATTEMPT_CYCLES + 1);
    localparam int unsigned BREAK_W   = $clog2(BREAK_CYCLES + 1);
    localparam int unsigned FLP_W     = $clog2(FLP_GAP_CYCLES + 1);
    localparam int unsigned JABBER_W  = $clog2(JABBER_CYCLES + 1);

    ctrl_state_type state;
    ctrl_state_type next_state;

    logic path_enabled;
    logic attempt_done;
    logic break_done;
    logic burst_due;
    logic jabber_trip;
    logic jabber_block;
    logic carrier_ok;
    logic squelch_ok;
    logic rx_invert;
    logic partner_compatible;

    assign path_enabled       = i_phy_power_enable && i_tx_path_enable && i_rx_path_enable;
    assign partner_compatible = i_partner_word[phy_ctrl_pkg::LCW_10HD] || i_partner_word[phy_ctrl_pkg::LCW_10FD];
    // Link loss only matters while link check is on; otherwise run blind
    assign carrier_ok = ((state.phase == phy_ctrl_pkg::PHASE_LINKED) || (state.phase == phy_ctrl_pkg::PHASE_MANUAL))
                        && !(i_link_check_enable && !state.link_good);
    assign squelch_ok = !i_smart_squelch_enable || (i_rx_amplitude_ok && i_rx_timing_ok);
    assign rx_invert  = i_auto_polarity_enable ? state.pol_flip : i_manual_polarity_invert;

    // Timers are cleared outside their phase, so every re-enable starts them afresh
    phy_interval_timer #(.WIDTH(ATTEMPT_W), .LIMIT(ATTEMPT_CYCLES)) u_attempt_timer (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_clear (state.phase != phy_ctrl_pkg::PHASE_ATTEMPT),
        .i_run   (1'b1),
        .o_done  (attempt_done)
    );

    phy_interval_timer #(.WIDTH(BREAK_W), .LIMIT(BREAK_CYCLES)) u_break_timer (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_clear (state.phase != phy_ctrl_pkg::PHASE_BREAK),
        .i_run   (1'b1),
        .o_done  (break_done)
    );

    phy_interval_timer #(.WIDTH(FLP_W), .LIMIT(FLP_GAP_CYCLES)) u_burst_timer (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_clear (state.phase != phy_ctrl_pkg::PHASE_ATTEMPT),
        .i_run   (1'b1),
        .o_done  (burst_due)
    );

    phy_jabber_guard #(.WIDTH(JABBER_W), .LIMIT(JABBER_CYCLES)) u_jabber_guard (
        .i_clock     (i_clock),
        .i_rst_n     (i_rst_n),
        .i_enable    (i_jabber_enable),
        .i_tx_active (i_mac_tx_en),
        .o_trip      (jabber_trip),
        .o_blocking  (jabber_block)
    );

    always_comb begin
        next_state                = state;
        next_state.complete_pulse = 1'b0;
        next_state.failed_pulse   = 1'b0;
        next_state.burst_pulse    = 1'b0;
        next_state.jabber_pulse   = jabber_trip;
        next_state.link_good      = i_link_pulse_ok;
        next_state.pol_flip       = i_auto_polarity_enable && i_polarity_reversed_detect;
        // A partner signal in the clear cycle still leaves the flag set
        if (i_link_pulse_ok || i_line_rx_valid) begin
            next_state.wake = 1'b1;
        end else if (i_wake_clear) begin
            next_state.wake = 1'b0;
        end
        if (jabber_trip) begin
            next_state.loopback = 1'b0;
        end else if (i_loopback_write) begin
            next_state.loopback = i_loopback_value;
        end
        if (!i_enable_a && i_duplex_write) begin
            next_state.duplex = i_duplex_value;
        end
        case (state.phase)
            phy_ctrl_pkg::PHASE_OFF: begin
                if (path_enabled) begin
                    next_state.fail_status  = phy_ctrl_pkg::FAIL_RESET;
                    next_state.remote_fault = 1'b0;
                    next_state.ack          = 1'b0;
                    if (i_enable_a) begin
                        next_state.phase       = phy_ctrl_pkg::PHASE_ATTEMPT;
                        next_state.burst_pulse = 1'b1;
                    end else begin
                        next_state.phase = phy_ctrl_pkg::PHASE_MANUAL;
                    end
                end
            end
            phy_ctrl_pkg::PHASE_ATTEMPT: begin
                if (burst_due) begin
                    next_state.burst_pulse = 1'b1;
                end
                if (i_partner_word_valid) begin
                    next_state.ack          = 1'b1;
                    next_state.remote_fault = i_partner_word[phy_ctrl_pkg::LCW_RFAULT];
                    if (partner_compatible) begin
                        next_state.complete_pulse = 1'b1;
                        next_state.duplex         = i_partner_word[phy_ctrl_pkg::LCW_10FD];
                        next_state.phase          = phy_ctrl_pkg::PHASE_LINKED;
                    end else begin
                        next_state.failed_pulse                            = 1'b1;
                        next_state.fail_status[phy_ctrl_pkg::FAIL_INCOMPAT] = 1'b1;
                        next_state.duplex                                  = 1'b0;
                        next_state.phase                                   = phy_ctrl_pkg::PHASE_BREAK;
                    end
                end else if (i_partner_nlp) begin
                    next_state.duplex = 1'b0;
                    next_state.phase  = phy_ctrl_pkg::PHASE_LINKED;
                end else if (attempt_done) begin
                    next_state.failed_pulse                           = 1'b1;
                    next_state.fail_status[phy_ctrl_pkg::FAIL_TIMEOUT] = 1'b1;
                    next_state.duplex                                 = 1'b0;
                    next_state.phase                                  = phy_ctrl_pkg::PHASE_BREAK;
                end
            end
            phy_ctrl_pkg::PHASE_BREAK: begin
                // Partner words are deliberately not looked at here
                if (break_done) begin
                    next_state.ack         = 1'b0;
                    next_state.phase       = phy_ctrl_pkg::PHASE_ATTEMPT;
                    next_state.burst_pulse = 1'b1;
                end
            end
            phy_ctrl_pkg::PHASE_LINKED: begin
                next_state.phase = phy_ctrl_pkg::PHASE_LINKED;
            end
            phy_ctrl_pkg::PHASE_MANUAL: begin
                next_state.phase = phy_ctrl_pkg::PHASE_MANUAL;
            end
            default: begin
                next_state.phase = phy_ctrl_pkg::PHASE_OFF;
            end
        endcase
        if (!path_enabled) begin
            next_state.phase = phy_ctrl_pkg::PHASE_OFF;
        end
        next_state.local_word = '0;
        next_state.local_word[phy_ctrl_pkg::LCW_SEL_LSB +: phy_ctrl_pkg::LCW_SEL_W] = phy_ctrl_pkg::LCW_SELECTOR;
        next_state.local_word[phy_ctrl_pkg::LCW_10HD]  = 1'b1;
        next_state.local_word[phy_ctrl_pkg::LCW_10FD]  = 1'b1;
        next_state.local_word[phy_ctrl_pkg::LCW_PAUSE] = i_pause_advertise;
        next_state.local_word[phy_ctrl_pkg::LCW_ACK]   = next_state.ack;
        next_state.tx_en   = carrier_ok && i_mac_tx_en && !state.loopback && !jabber_block;
        next_state.tx_data = i_mac_tx_data;
        if (state.loopback) begin
            // Loopback ignores link check: the line is isolated and pulses vanish
            next_state.rx_valid = path_enabled && i_mac_tx_en;
            next_state.rx_data  = i_mac_tx_data;
        end else begin
            next_state.rx_valid = carrier_ok && i_line_rx_valid && squelch_ok;
            next_state.rx_data  = i_line_rx_data ^ rx_invert;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state             <= '0;
            state.phase       <= phy_ctrl_pkg::PHASE_OFF;
            state.fail_status <= phy_ctrl_pkg::FAIL_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign o_duplex_select               = state.duplex;
    assign o_loopback                    = state.loopback;
    assign o_remote_fault                = state.remote_fault;
    assign o_link_good                   = state.link_good;
    assign o_polarity_flipped            = state.pol_flip;
    assign o_wake_event_flag             = state.wake;
    assign o_negotiation_fail_status_reg = state.fail_status;
    assign o_neg_complete                = state.complete_pulse;
    assign o_neg_failed                  = state.failed_pulse;
    assign o_jabber_detected             = state.jabber_pulse;
    assign o_local_word                  = state.local_word;
    assign o_flp_burst                   = state.burst_pulse;
    assign o_line_tx_en                  = state.tx_en;
    assign o_line_tx_data                = state.tx_data;
    assign o_mac_rx_valid                = state.rx_valid;
    assign o_mac_rx_data                 = state.rx_data;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    a_burst_in_attempt: assert property ((state.phase == phy_ctrl_pkg::PHASE_ATTEMPT) && burst_due
        |=> o_flp_burst)
        else $error("burst not sent at burst interval");
    a_fail_half_duplex: assert property (o_neg_failed |-> !o_duplex_select)
        else $error("failure did not fall back to half duplex");
    a_complete_only: assert property (o_neg_complete |-> !o_neg_failed)
        else $error("complete and failed raised together");
    a_speed_advert: assert property (1'b1
        |=> o_local_word[phy_ctrl_pkg::LCW_10HD] && o_local_word[phy_ctrl_pkg::LCW_10FD])
        else $error("10 Mb/s not advertised");
    a_pause_advert: assert property (i_pause_advertise |=> o_local_word[phy_ctrl_pkg::LCW_PAUSE])
        else $error("pause not advertised");
    a_restart_attempt: assert property ((state.phase == phy_ctrl_pkg::PHASE_OFF) && path_enabled && i_enable_a
        |=> (state.phase == phy_ctrl_pkg::PHASE_ATTEMPT) && o_flp_burst)
        else $error("re-enable did not restart negotiation");
    a_timeout_break: assert property ((state.phase == phy_ctrl_pkg::PHASE_ATTEMPT) && attempt_done
        && path_enabled && !i_partner_word_valid && !i_partner_nlp
        |=> (state.phase == phy_ctrl_pkg::PHASE_BREAK) && o_neg_failed
            && o_negotiation_fail_status_reg[phy_ctrl_pkg::FAIL_TIMEOUT])
        else $error("attempt timeout did not enter break link");
    a_break_deaf: assert property ((state.phase == phy_ctrl_pkg::PHASE_BREAK) |=> !o_neg_complete)
        else $error("negotiated during break link");
    a_loop_isolate: assert property (o_loopback |=> !o_line_tx_en)
        else $error("line driven in loopback");
    // Receive in the next cycle follows the loopback bit that stood when it was computed
    a_link_drop: assert property (i_link_check_enable && !o_link_good
        |=> !o_line_tx_en && ($past(o_loopback) || !o_mac_rx_valid))
        else $error("path active on failed link");
    a_manual_invert: assert property (!i_auto_polarity_enable && i_manual_polarity_invert
        && !o_loopback && i_line_rx_valid |=> o_mac_rx_data == !$past(i_line_rx_data))
        else $error("manual polarity not applied");
    a_jabber_clear_loop: assert property (jabber_trip |=> !o_loopback && o_jabber_detected)
        else $error("jabber did not clear loopback");
    a_duplex_locked: assert property (i_enable_a && (state.phase != phy_ctrl_pkg::PHASE_ATTEMPT)
        |=> $stable(o_duplex_select))
        else $error("duplex changed under enable_a");

    c_complete: cover property (o_neg_complete && o_duplex_select);
    c_failed: cover property (o_neg_failed);
    c_jabber: cover property (jabber_trip && state.loopback);
    c_linked_tx: cover property ((state.phase == phy_ctrl_pkg::PHASE_LINKED) && o_line_tx_en);
endmodule
`default_nettype wire

// *** phy_link_partner.sv ***
// Far-end station model that sends code words or legacy link pulses
`timescale 1ns/1ps
`default_nettype none
module phy_link_partner (
    input  wire logic        i_clock,
    input  wire logic        i_send,
    input  wire logic        i_legacy,
    input  wire logic [15:0] i_word,
    output logic             o_word_valid,
    output logic [15:0]      o_word,
    output logic             o_nlp
);
    initial {o_word_valid, o_word, o_nlp} = '0;
    // Between words the bus toggles so a stale value is never mistaken for a new one
    always @(posedge i_clock) begin
        o_word_valid <= i_send;
        o_word       <= i_send ? i_word : ~o_word;
        o_nlp        <= i_legacy;
    end
endmodule
`default_nettype wire

// *** test_tenbase_t_phy_control.sv ***
// Self-checking bench for the physical layer control block
`timescale 1ns/1ps
`default_nettype none
module test_tenbase_t_phy_control;
    logic i_clock, i_rst_n, pw, txe, rxe, dw, dv, lw, lv, an, pa, ce, je, mi, mt, md, lrv, lrd, snd, leg;
    logic [15:0] sw, pword;
    logic pvalid, pnlp, dup, lb, lg, pf, wk, nc, nf, jd, ft, ltx, ltd, mrv, mrd, pause, d, hit;
    logic [7:0] fst;
    logic [15:0] lw16;
    logic sq, ap, wc, lpo, amp, tim, prd, rf;
    int n_mismatch = 0, n_compared = 0;
    wire [3:0] ev = {nc, nf, ft, jd};
    phy_link_partner peer (.i_clock(i_clock), .i_send(snd), .i_legacy(leg), .i_word(sw),
        .o_word_valid(pvalid), .o_word(pword), .o_nlp(pnlp));
    tenbase_t_phy_control #(.ATTEMPT_CYCLES(50), .BREAK_CYCLES(80), .FLP_GAP_CYCLES(10), .JABBER_CYCLES(20)) dut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_phy_power_enable(pw), .i_tx_path_enable(txe),
        .i_rx_path_enable(rxe), .i_duplex_write(dw), .i_duplex_value(dv), .i_loopback_write(lw),
        .i_loopback_value(lv), .i_enable_a(an), .i_pause_advertise(pa), .i_smart_squelch_enable(sq),
        .i_link_check_enable(ce), .i_jabber_enable(je), .i_auto_polarity_enable(ap),
        .i_manual_polarity_invert(mi), .i_wake_clear(wc), .i_partner_word_valid(pvalid),
        .i_partner_word(pword), .i_partner_nlp(pnlp), .i_link_pulse_ok(lpo), .i_line_rx_valid(lrv),
        .i_line_rx_data(lrd), .i_rx_amplitude_ok(amp), .i_rx_timing_ok(tim),
        .i_polarity_reversed_detect(prd), .i_mac_tx_en(mt), .i_mac_tx_data(md), .o_duplex_select(dup),
        .o_loopback(lb), .o_remote_fault(rf), .o_link_good(lg), .o_polarity_flipped(pf),
        .o_wake_event_flag(wk), .o_negotiation_fail_status_reg(fst), .o_neg_complete(nc),
        .o_neg_failed(nf), .o_jabber_detected(jd), .o_local_word(lw16), .o_flp_burst(ft),
        .o_line_tx_en(ltx), .o_line_tx_data(ltd), .o_mac_rx_valid(mrv), .o_mac_rx_data(mrd));
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    function automatic logic [15:0] adv_word(input logic p);
        return 16'h0061 | (16'(p) << 10);
    endfunction
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    // Bounded wait for one event pulse; hit tells whether it came
    task automatic await(input int k, input int lim);
        hit = 1'b0;
        repeat (lim) begin
            @(posedge i_clock);
            #1;
            if (ev[k] === 1'b1) begin
                hit = 1'b1;
                break;
            end
        end
        @(negedge i_clock);
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        {pw, txe, rxe, dw, dv, lw, lv, an, pa, ce, je, mi, mt, md, lrv, lrd, snd, leg, sw} = '0;
        {sq, ap, wc, prd, lpo, amp, tim} = 7'h07;
        i_rst_n = 1'b0;
        void'($urandom(32'h6e865f5d));
        repeat (10) @(negedge i_clock);
        i_rst_n = 1'b1;
        pause = 1'($urandom);
        {pa, an} = {pause, 1'b1};
        {pw, txe, rxe} = 3'b111;
        await(1, 5);
        chk(hit && lw16 === adv_word(pause), "advertised word");
        {snd, sw} = {1'b1, 16'h2041};
        @(negedge i_clock) snd = 1'b0;
        await(3, 10);
        chk(hit && dup === 1'b1 && nf === 1'b0, "full duplex not chosen");
        chk(rf === 1'b1 && lw16[14] === 1'b1, "fault or acknowledge");
        {dw, dv} = 2'b10;
        @(negedge i_clock) dw = 1'b0;
        @(negedge i_clock) chk(dup === 1'b1, "duplex written under negotiation");
        txe = 1'b0;
        @(negedge i_clock) txe = 1'b1;
        await(2, 60);
        chk(hit && fst[5] === 1'b1 && dup === 1'b0 && rf === 1'b0, "timeout failure");
        {snd, sw} = {1'b1, 16'h0041};
        @(negedge i_clock) snd = 1'b0;
        await(3, 20);
        chk(!hit, "word taken in break");
        await(1, 80);
        chk(hit, "no attempt after break");
        leg = 1'b1;
        @(negedge i_clock) leg = 1'b0;
        // Long enough that an ignored legacy pulse would end in an attempt timeout
        await(2, 60);
        chk(!hit && dup === 1'b0, "legacy partner");
        {pw, an, ce} = 3'b000;
        @(negedge i_clock) {dw, dv, lw, lv} = 4'b1111;
        @(negedge i_clock) {dw, lw, pw} = 3'b001;
        @(negedge i_clock) chk(dup === 1'b1 && lb === 1'b1 && wk === 1'b1, "manual setup");
        repeat (8) begin
            d = 1'($urandom);
            {mt, md} = {1'b1, d};
            @(negedge i_clock) chk(mrd === d && mrv === 1'b1 && ltx === 1'b0, "loopback path");
        end
        je = 1'b1;
        await(0, 30);
        chk(hit && lb === 1'b0, "jabber");
        {mt, mi, lrv} = 3'b011;
        repeat (8) begin
            d = 1'($urandom);
            lrd = d;
            @(negedge i_clock) chk(mrd === ~d && mrv === 1'b1, "manual invert");
        end
        // Each draw stands two edges: link and polarity status reach the data path one cycle late
        repeat (8) begin
            {sq, ap, prd, amp, tim, lrd, ce, lpo, mt, md} = 10'($urandom);
            repeat (2) @(negedge i_clock);
            chk(lg === lpo && pf === (ap & prd) && wk === 1'b1, "status bits");
            chk(mrv === ((lpo | !ce) & (!sq | amp & tim)), "receive gating");
            chk(mrd === (lrd ^ (ap ? prd : mi)), "receive polarity");
            chk(ltx === ((lpo | !ce) & mt) && ltd === md, "transmit gating");
        end
        {lrv, lpo, wc} = 3'b001;
        @(negedge i_clock) chk(wk === 1'b0, "wake not cleared");
        lpo = 1'b1;
        @(negedge i_clock) chk(wk === 1'b1, "wake clear beat a new signal");
        complete_run();
    end
endmodule
`default_nettype wire
